// ==== core/ctp_defs.svh ====
`ifndef CTP_DEFS_SVH
`define CTP_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CTP_ADDR_W        4
`define CTP_OFS_LCTRL     4'h0
`define CTP_OFS_UCTRL     4'h1
`define CTP_OFS_CMPL      4'h2
`define CTP_OFS_CMPH      4'h3
`define CTP_OFS_DUTL      4'h4
`define CTP_OFS_DUTH      4'h5
`define CTP_OFS_SYSCFG    4'h6
`define CTP_OFS_CNTL      4'h7
`define CTP_OFS_CNTH      4'h8
`define CTP_OFS_STATUS    4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTP_MODE_MSB      2
`define CTP_MODE_LSB      0
`define CTP_CLK_MSB       6
`define CTP_CLK_LSB       4
`define CTP_UC_RUN        3
`define CTP_UC_FFINIT     7
`define CTP_CFG_DV        0
`define CTP_CFG_SLOW      1

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define CTP_MODE_16TMR    3'h4
`define CTP_MODE_16PWM    3'h6
`define CTP_CLK_EXT       3'h7
`define CTP_RST_BYTE      8'h00
`define CTP_RST_WORD      16'h0000

// ----------------------------------------
// Prescaler exponents
// ----------------------------------------
`define CTP_PRE_A         11
`define CTP_PRE_B         7
`define CTP_PRE_C         5
`define CTP_PRE_D         3
`define CTP_PRE_E         1
`define CTP_FS_DIV_W      3

`endif

// ==== core/ctp_pkg.sv ====
package ctp_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [7:0]  ctp_byte_t;
    typedef logic [15:0] ctp_word_t;
    typedef logic [3:0]  ctp_addr_t;

    typedef enum logic [1:0] {
        CTP_IDLE,
        CTP_TIMER,
        CTP_EVENT,
        CTP_PWM
    } ctp_mode_t;

endpackage

// ==== core/ctp_prescaler.sv ====
`timescale 1ns/10ps
`include "ctp_defs.svh"
module ctp_prescaler #(
    parameter int DIV_W = `CTP_PRE_A
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Slow oscillator pin
    input  wire logic low_freq_clock,
    // Tick outputs
    ctp_tick_if.src   ticks
);
    import ctp_pkg::*;

    generate
        if (DIV_W < `CTP_PRE_A) begin : g_chk
            $error("ctp_prescaler: DIV_W too small");
        end
    endgenerate

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic low_ones(input logic [DIV_W-1:0] v,
                                      input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < n; i++) begin
            r = r & v[i];
        end
        return r;
    endfunction

    logic [DIV_W-1:0]         div_cnt;
    logic [`CTP_FS_DIV_W-1:0] fs_cnt;
    logic                     fs_s1;
    logic                     fs_s2;
    logic                     fs_s3;
    logic                     fs_rise;

    // The second and third stages feed the edge detector
    assign fs_rise = fs_s2 & ~fs_s3;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt        <= '0;
            fs_cnt         <= '0;
            fs_s1          <= 1'b0;
            fs_s2          <= 1'b0;
            fs_s3          <= 1'b0;
            ticks.fc_d2    <= 1'b0;
            ticks.fc_d8    <= 1'b0;
            ticks.fc_d32   <= 1'b0;
            ticks.fc_d128  <= 1'b0;
            ticks.fc_d2048 <= 1'b0;
            ticks.fs_tick  <= 1'b0;
            ticks.fs_d8    <= 1'b0;
        end else begin
            div_cnt        <= div_cnt + 1'b1;
            fs_s1          <= low_freq_clock;
            fs_s2          <= fs_s1;
            fs_s3          <= fs_s2;
            ticks.fc_d2    <= low_ones(div_cnt, `CTP_PRE_E);
            ticks.fc_d8    <= low_ones(div_cnt, `CTP_PRE_D);
            ticks.fc_d32   <= low_ones(div_cnt, `CTP_PRE_C);
            ticks.fc_d128  <= low_ones(div_cnt, `CTP_PRE_B);
            ticks.fc_d2048 <= low_ones(div_cnt, `CTP_PRE_A);
            ticks.fs_tick  <= fs_rise;
            ticks.fs_d8    <= fs_rise & (&fs_cnt);
            if (fs_rise) begin
                fs_cnt <= fs_cnt + 1'b1;
            end
        end
    end

endmodule

// ==== core/ctp_tick_if.sv ====
`timescale 1ns/10ps
interface ctp_tick_if;
    logic fc_d2;
    logic fc_d8;
    logic fc_d32;
    logic fc_d128;
    logic fc_d2048;
    logic fs_tick;
    logic fs_d8;

    modport src (output fc_d2, fc_d8, fc_d32, fc_d128, fc_d2048,
                 output fs_tick, fs_d8);
    modport dst (input  fc_d2, fc_d8, fc_d32, fc_d128, fc_d2048,
                 input  fs_tick, fs_d8);
endinterface

// ==== core/ctp_timer.sv ====
// Summary of operation
// - 16-bit modes chain both byte counters; timer mode counts prescaled ticks.
// - Once run, a count equal to compare pulses irq, clears, keeps counting.
// - Compare has no shadow; a written value matches right away.
// - Timer clocks: fast/2048,/128,/32,/8; slow/8 via divider bit or slow mode.
// - Event mode counts each falling edge of the external input pin.
// - Event mode match pulses irq and clears; counting resumes on edges.
// - PWM mode gives 16-bit resolution from internal or external clock.
// - PWM duty match and overflow each toggle flip-flop, none if both; overflow clears, pulses irq.
// - Flip-flop loads start level from initial bit; reset clears it.
// - PWM pin always shows the inverse of the output flip-flop.
// - Running duty writes go to holding, move at overflow; stopped, at once.
// - Duty reads while PWM runs show the value in effect, old until overflow.
// - Stopping holds pin level; level changes only by a later separate write.
// - PWM adds slow clock, fast/2 and fast clock; period is 65536 ticks.
`timescale 1ns/10ps
`include "ctp_defs.svh"
module ctp_timer (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // Register port
    input  wire ctp_pkg::ctp_addr_t reg_addr,
    input  wire ctp_pkg::ctp_byte_t reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output ctp_pkg::ctp_byte_t     reg_rdata,
    // Pins
    input  wire logic              event_input_pin,
    input  wire logic              low_freq_clock,
    output logic                   pwm_output_pin,
    // Event
    output logic                   upper_counter_irq
);
    import ctp_pkg::*;

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    ctp_tick_if tick_bus ();

    ctp_prescaler #(
        .DIV_W          (`CTP_PRE_A)
    ) u_prescaler (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .low_freq_clock (low_freq_clock),
        .ticks          (tick_bus)
    );

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    ctp_byte_t  lower_control_reg;
    ctp_byte_t  upper_control_reg;
    ctp_byte_t  compare_low_byte;
    ctp_byte_t  compare_high_byte;
    ctp_byte_t  duty_low_byte;
    ctp_byte_t  duty_high_byte;
    ctp_byte_t  sys_config;
    ctp_word_t  duty_active;
    ctp_byte_t  cnt_lo;
    ctp_byte_t  cnt_hi;
    logic       output_flipflop;
    logic       ev_s1;
    logic       ev_s2;
    logic       ev_s3;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic       wr_lctrl;
    logic       wr_uctrl;
    logic       wr_cmpl;
    logic       wr_cmph;
    logic       wr_dutl;
    logic       wr_duth;
    logic       wr_cfg;
    logic       run_bit;
    logic       divider_select_bit;
    logic       slow_mode;
    logic [2:0] lmode;
    logic [2:0] umode;
    logic [2:0] clk_sel;
    logic       both_tmr;
    logic       both_pwm;
    ctp_mode_t  mode;
    logic       is_pwm;

    assign wr_lctrl = reg_wr && (reg_addr == `CTP_OFS_LCTRL);
    assign wr_uctrl = reg_wr && (reg_addr == `CTP_OFS_UCTRL);
    assign wr_cmpl  = reg_wr && (reg_addr == `CTP_OFS_CMPL);
    assign wr_cmph  = reg_wr && (reg_addr == `CTP_OFS_CMPH);
    assign wr_dutl  = reg_wr && (reg_addr == `CTP_OFS_DUTL);
    assign wr_duth  = reg_wr && (reg_addr == `CTP_OFS_DUTH);
    assign wr_cfg   = reg_wr && (reg_addr == `CTP_OFS_SYSCFG);

    assign run_bit            = upper_control_reg[`CTP_UC_RUN];
    assign divider_select_bit = sys_config[`CTP_CFG_DV];
    assign slow_mode          = sys_config[`CTP_CFG_SLOW];
    assign lmode   = lower_control_reg[`CTP_MODE_MSB:`CTP_MODE_LSB];
    assign umode   = upper_control_reg[`CTP_MODE_MSB:`CTP_MODE_LSB];
    assign clk_sel = lower_control_reg[`CTP_CLK_MSB:`CTP_CLK_LSB];

    // Both halves must agree, else the pair stays idle
    assign both_tmr = (lmode == `CTP_MODE_16TMR)
                   && (umode == `CTP_MODE_16TMR);
    assign both_pwm = (lmode == `CTP_MODE_16PWM)
                   && (umode == `CTP_MODE_16PWM);
    assign mode = both_pwm ? CTP_PWM
                : !both_tmr ? CTP_IDLE
                : (clk_sel == `CTP_CLK_EXT) ? CTP_EVENT : CTP_TIMER;
    assign is_pwm = (mode == CTP_PWM);

    // ----------------------------------------
    // Count source
    // ----------------------------------------
    logic       ev_fall;
    logic       slow_div;
    logic [7:0] src_normal;
    logic [7:0] src_slow;
    logic       src_sel;
    logic       tick;

    // Falling edge taken after the two sync stages only
    assign ev_fall  = ev_s3 & ~ev_s2;
    assign slow_div = divider_select_bit ? tick_bus.fs_d8
                                         : tick_bus.fc_d2048;

    // Fast-only sources disappear in slow mode; the extra
    // three PWM sources are refused in timer mode
    assign src_normal = {ev_fall,
                         is_pwm,
                         is_pwm & tick_bus.fc_d2,
                         is_pwm & tick_bus.fs_tick,
                         tick_bus.fc_d8,
                         tick_bus.fc_d32,
                         tick_bus.fc_d128,
                         slow_div};
    assign src_slow   = {ev_fall,
                         2'b00,
                         is_pwm & tick_bus.fs_tick,
                         3'b000,
                         tick_bus.fs_d8};
    assign src_sel = slow_mode ? src_slow[clk_sel] : src_normal[clk_sel];
    assign tick    = run_bit && (mode != CTP_IDLE) && src_sel;

    // ----------------------------------------
    // Counter and match
    // ----------------------------------------
    ctp_word_t  count;
    logic       lo_carry;
    logic       cmp_hit;
    logic       duty_hit;
    logic       ovf;
    logic       wrap;
    logic       clear;
    ctp_byte_t  next_lo;
    ctp_byte_t  next_hi;

    assign count    = {cnt_hi, cnt_lo};
    assign lo_carry = (cnt_lo == 8'hff);
    // Compare bytes are used directly, so a write acts at once
    assign cmp_hit  = (count == {compare_high_byte,
                                 compare_low_byte});
    assign duty_hit = (count == duty_active);
    assign ovf      = &count;
    assign wrap     = tick && (is_pwm ? ovf : cmp_hit);
    assign clear    = !run_bit || wrap;

    assign next_lo = clear ? `CTP_RST_BYTE
                   : tick ? cnt_lo + 8'h01 : cnt_lo;
    assign next_hi = clear ? `CTP_RST_BYTE
                   : (tick && lo_carry) ? cnt_hi + 8'h01 : cnt_hi;

    // ----------------------------------------
    // Output flip-flop and duty transfer
    // ----------------------------------------
    logic       ff_load;
    logic       ff_flip;
    logic       next_ff;
    ctp_word_t  duty_hold;
    ctp_word_t  next_duty;

    // Start level only loads while already stopped, so a
    // stopping write never disturbs the held pin level
    assign ff_load = wr_uctrl && !run_bit;
    assign ff_flip = tick && is_pwm && (duty_hit ^ ovf);
    assign next_ff = ff_load ? reg_wdata[`CTP_UC_FFINIT]
                   : output_flipflop ^ ff_flip;
    assign duty_hold = {duty_high_byte, duty_low_byte};
    assign next_duty = (!run_bit || (wrap && is_pwm)) ? duty_hold
                                                      : duty_active;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    ctp_word_t  duty_view;
    ctp_byte_t  next_rdata;

    // Running PWM shows the duty in effect, old until overflow
    assign duty_view = (run_bit && is_pwm) ? duty_active
                                           : duty_hold;
    assign next_rdata =
          !reg_rd                          ? `CTP_RST_BYTE
        : (reg_addr == `CTP_OFS_LCTRL)     ? lower_control_reg
        : (reg_addr == `CTP_OFS_UCTRL)     ? upper_control_reg
        : (reg_addr == `CTP_OFS_CMPL)      ? compare_low_byte
        : (reg_addr == `CTP_OFS_CMPH)      ? compare_high_byte
        : (reg_addr == `CTP_OFS_DUTL)      ? duty_view[7:0]
        : (reg_addr == `CTP_OFS_DUTH)      ? duty_view[15:8]
        : (reg_addr == `CTP_OFS_SYSCFG)    ? sys_config
        : (reg_addr == `CTP_OFS_CNTL)      ? cnt_lo
        : (reg_addr == `CTP_OFS_CNTH)      ? cnt_hi
        : (reg_addr == `CTP_OFS_STATUS)    ? {6'b00_0000,
                                              output_flipflop, run_bit}
        : `CTP_RST_BYTE;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lower_control_reg <= `CTP_RST_BYTE;
            upper_control_reg <= `CTP_RST_BYTE;
            compare_low_byte  <= `CTP_RST_BYTE;
            compare_high_byte <= `CTP_RST_BYTE;
            duty_low_byte     <= `CTP_RST_BYTE;
            duty_high_byte    <= `CTP_RST_BYTE;
            sys_config        <= `CTP_RST_BYTE;
        end else begin
            if (wr_lctrl) lower_control_reg <= reg_wdata;
            if (wr_uctrl) upper_control_reg <= reg_wdata;
            if (wr_cmpl)  compare_low_byte  <= reg_wdata;
            if (wr_cmph)  compare_high_byte <= reg_wdata;
            if (wr_dutl)  duty_low_byte     <= reg_wdata;
            if (wr_duth)  duty_high_byte    <= reg_wdata;
            if (wr_cfg)   sys_config        <= reg_wdata;
        end
    end

    // ----------------------------------------
    // Counter, flip-flop, pins
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_lo            <= `CTP_RST_BYTE;
            cnt_hi            <= `CTP_RST_BYTE;
            duty_active       <= `CTP_RST_WORD;
            output_flipflop   <= 1'b0;
            pwm_output_pin    <= 1'b1;
            upper_counter_irq <= 1'b0;
            reg_rdata         <= `CTP_RST_BYTE;
        end else begin
            cnt_lo            <= next_lo;
            cnt_hi            <= next_hi;
            duty_active       <= next_duty;
            output_flipflop   <= next_ff;
            pwm_output_pin    <= ~next_ff;
            upper_counter_irq <= wrap;
            reg_rdata         <= next_rdata;
        end
    end

    // ----------------------------------------
    // Event pin synchroniser
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ev_s1 <= 1'b1;
            ev_s2 <= 1'b1;
            ev_s3 <= 1'b1;
        end else begin
            ev_s1 <= event_input_pin;
            ev_s2 <= ev_s1;
            ev_s3 <= ev_s2;
        end
    end

endmodule

// ==== test/ctp_ext_model.sv ====
`timescale 1ns/10ps
module ctp_ext_model (
    // Clock
    input  wire logic sys_clk,
    // Pins
    input  wire logic pwm_output_pin,
    output logic      event_input_pin,
    output logic      low_freq_clock
);
    int pin_edges;

    // Oscillator runs free, exactly 16 system periods
    initial begin
        event_input_pin = 1'b1;
        low_freq_clock  = 1'b0;
        pin_edges       = 0;
        #137;
        forever begin
            #800 low_freq_clock = ~low_freq_clock;
        end
    end

    // Port latch taken as set, so the load sees every pin change
    always @(pwm_output_pin) pin_edges++;

    // Four cycles a level leaves margin over the synchroniser
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge sys_clk) event_input_pin <= 1'b0;
            repeat (4) @(posedge sys_clk);
            event_input_pin <= 1'b1;
            repeat (4) @(posedge sys_clk);
        end
    endtask
endmodule

// ==== test/ctp_timer_asserts.sv ====
`timescale 1ns/10ps
`include "ctp_defs.svh"
module ctp_timer_asserts (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               rst_n,
    // Register port
    input wire ctp_pkg::ctp_addr_t reg_addr,
    input wire ctp_pkg::ctp_byte_t reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire ctp_pkg::ctp_byte_t reg_rdata,
    // Pins and event
    input wire logic               event_input_pin,
    input wire logic               low_freq_clock,
    input wire logic               pwm_output_pin,
    input wire logic               upper_counter_irq
);
    import ctp_pkg::*;

    // ------
    // Run bit shadow, rebuilt from port writes
    // ------
    logic      run_q;
    wire logic uc_wr;
    assign uc_wr = reg_wr && reg_addr == `CTP_OFS_UCTRL;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (uc_wr) begin
            run_q <= reg_wdata[`CTP_UC_RUN];
        end
    end

    // ------
    // Properties
    // ------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_uc_wr_idle;
        uc_wr && !run_q;
    endsequence

    sequence s_status_rd;
        reg_rd && reg_addr == `CTP_OFS_STATUS;
    endsequence

    rdata_idle_a: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    unmapped_zero_a: assert property (
        reg_rd && reg_addr > `CTP_OFS_STATUS |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    status_view_a: assert property (
        s_status_rd |=>
        reg_rdata == {6'h00, !$past(pwm_output_pin), $past(run_q)})
        else $error("status does not match pin and run bit");
    ffinit_load_a: assert property (
        s_uc_wr_idle |=> pwm_output_pin == !$past(reg_wdata[7]))
        else $error("stopped control write did not set pin level");
    stop_hold_a: assert property (
        !run_q && !uc_wr |=> $stable(pwm_output_pin))
        else $error("pin moved while stopped");
    stop_noirq_a: assert property (
        !run_q |=> !upper_counter_irq)
        else $error("interrupt while stopped");
    irq_single_a: assert property (
        upper_counter_irq |=> !upper_counter_irq)
        else $error("interrupt pulse longer than one cycle");
    reset_pin_a: assert property (
        $rose(rst_n) |-> pwm_output_pin && !upper_counter_irq)
        else $error("pin or interrupt wrong after reset");
    count_stopped_a: assert property (
        reg_rd && reg_addr == `CTP_OFS_CNTL && !run_q && !$past(run_q)
        |=> reg_rdata == 8'h00)
        else $error("count not zero while stopped");
endmodule

bind ctp_timer ctp_timer_asserts i_ctp_timer_asserts (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .event_input_pin(event_input_pin),
    .low_freq_clock(low_freq_clock), .pwm_output_pin(pwm_output_pin),
    .upper_counter_irq(upper_counter_irq)
);

// ==== test/ctp_timer_bench.sv ====
`timescale 1ns/10ps
`include "ctp_defs.svh"
module ctp_timer_bench;
    import ctp_pkg::*;

    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  lctl;
        logic [15:0] cmp;
        logic [15:0] gap;
    } ctp_row_t;

    logic      sys_clk;
    logic      rst_n;
    ctp_addr_t reg_addr;
    ctp_byte_t reg_wdata;
    logic      reg_wr;
    logic      reg_rd;
    ctp_byte_t reg_rdata;
    logic      event_input_pin;
    logic      low_freq_clock;
    logic      pwm_output_pin;
    logic      upper_counter_irq;
    int        fail_count = 0;
    int        total_checks = 0;
    int        cyc = 0;
    int        irq_cnt = 0;
    int        t0;
    int        n0;
    ctp_byte_t rd_val;
    logic      lvl;
    ctp_row_t  rows [7];

    ctp_timer i_ctp_timer (
        .sys_clk          (sys_clk),
        .rst_n            (rst_n),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .event_input_pin  (event_input_pin),
        .low_freq_clock   (low_freq_clock),
        .pwm_output_pin   (pwm_output_pin),
        .upper_counter_irq(upper_counter_irq)
    );

    ctp_ext_model i_ctp_ext_model (
        .sys_clk        (sys_clk),
        .pwm_output_pin (pwm_output_pin),
        .event_input_pin(event_input_pin),
        .low_freq_clock (low_freq_clock)
    );

    // ------
    // Clock, watchdog and event tally
    // ------
    initial begin
        sys_clk = 1'b0;
        forever begin
            #50 sys_clk = ~sys_clk;
        end
    end

    // Sampled a cycle late, but the same lag on both ends of a gap
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (upper_counter_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    initial begin
        repeat (98000) @(posedge sys_clk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test();
    end

    // ------
    // Tasks
    // ------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input ctp_addr_t a, input ctp_byte_t d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input ctp_addr_t a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        rd_val = reg_rdata;
    endtask

    task automatic wait_irq;
        int n;
        n = irq_cnt;
        repeat (5000) begin
            @(posedge sys_clk);
            if (irq_cnt != n) return;
        end
        fail_count++;
        $display("[ERR] %0t no interrupt", $time);
    endtask

    task automatic wait_pin(input logic v, input int lim);
        repeat (lim) begin
            @(posedge sys_clk);
            if (pwm_output_pin === v) return;
        end
        fail_count++;
        $display("[ERR] %0t pin level not reached", $time);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------
    // Sequence
    // ------
    initial begin
        rst_n     = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        rows = '{'{8'h00, 8'h34, 16'h0004, 16'h0028},
                 '{8'h00, 8'h24, 16'h0001, 16'h0040},
                 '{8'h00, 8'h14, 16'h0000, 16'h0080},
                 '{8'h00, 8'h04, 16'h0000, 16'h0800},
                 '{8'h00, 8'h34, 16'h0100, 16'h0808},
                 '{8'h01, 8'h04, 16'h0000, 16'h0080},
                 '{8'h02, 8'h04, 16'h0000, 16'h0080}};
        repeat (8) @(posedge sys_clk);
        chk({pwm_output_pin, upper_counter_irq, reg_rdata}, 32'h0200);
        rst_n <= 1'b1;
        rd(`CTP_OFS_STATUS);
        chk(rd_val, 8'h00);
        rd(`CTP_OFS_CNTL);
        chk(rd_val, 8'h00);
        wr(4'hC, 8'hFF);
        rd(4'hC);
        chk(rd_val, 8'h00);
        foreach (rows[i]) begin
            wr(`CTP_OFS_SYSCFG, rows[i].cfg);
            wr(`CTP_OFS_CMPL, rows[i].cmp[7:0]);
            wr(`CTP_OFS_CMPH, rows[i].cmp[15:8]);
            wr(`CTP_OFS_LCTRL, rows[i].lctl);
            wr(`CTP_OFS_UCTRL, 8'h0C);
            wait_irq();
            t0 = cyc;
            wait_irq();
            chk(cyc - t0, {16'h0000, rows[i].gap});
            wr(`CTP_OFS_UCTRL, 8'h04);
        end
        wr(`CTP_OFS_SYSCFG, 8'h00);
        // Reset in mid-run must drop everything at once
        wr(`CTP_OFS_UCTRL, 8'h0C);
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        chk({pwm_output_pin, upper_counter_irq, reg_rdata}, 32'h0200);
        rst_n <= 1'b1;
        wr(`CTP_OFS_CMPL, 8'h05);
        wr(`CTP_OFS_CMPH, 8'h00);
        wr(`CTP_OFS_LCTRL, 8'h74);
        wr(`CTP_OFS_UCTRL, 8'h0C);
        i_ctp_ext_model.pulse(2);
        rd(`CTP_OFS_CNTL);
        chk(rd_val, 8'h02);
        n0 = irq_cnt;
        // Compare lowered on purpose while running
        wr(`CTP_OFS_CMPL, 8'h02);
        i_ctp_ext_model.pulse(1);
        chk(irq_cnt - n0, 1);
        i_ctp_ext_model.pulse(1);
        rd(`CTP_OFS_CNTL);
        chk(rd_val, 8'h01);
        wr(`CTP_OFS_UCTRL, 8'h04);
        wr(`CTP_OFS_DUTL, 8'h10);
        wr(`CTP_OFS_DUTH, 8'h00);
        wr(`CTP_OFS_LCTRL, 8'h66);
        wr(`CTP_OFS_UCTRL, 8'h06);
        wr(`CTP_OFS_UCTRL, 8'h0E);
        wait_pin(1'b0, 100);
        t0 = cyc;
        n0 = irq_cnt;
        // Written early in the period, well clear of the overflow
        wr(`CTP_OFS_DUTL, 8'h20);
        wr(`CTP_OFS_DUTH, 8'h00);
        rd(`CTP_OFS_DUTL);
        chk(rd_val, 8'h10);
        wait_pin(1'b1, 70000);
        chk(cyc - t0, 32'h0000_FFEF);
        repeat (2) @(posedge sys_clk);
        chk(irq_cnt - n0, 1);
        rd(`CTP_OFS_DUTL);
        chk(rd_val, 8'h20);
        wr(`CTP_OFS_UCTRL, 8'h06);
        @(posedge sys_clk);
        lvl = pwm_output_pin;
        repeat (100) @(posedge sys_clk);
        chk(pwm_output_pin, lvl);
        wr(`CTP_OFS_UCTRL, 8'h86);
        @(posedge sys_clk);
        chk(pwm_output_pin, 1'b0);
        rd(`CTP_OFS_STATUS);
        chk(rd_val, 8'h02);
        finish_test();
    end
endmodule
